// File: rtl/pbac_pkg.sv
// Package for the power budget and ACS configuration register block.
// Assumes a 32-bit AXI4-Lite register bus with aligned word accesses.
package pbac_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_PB_HDR    = 12'h20C; // Budget cap header
  localparam logic [11:0] OFF_PB_SEL    = 12'h210; // Data select index
  localparam logic [11:0] OFF_PB_DATA   = 12'h214; // Budget data word
  localparam logic [11:0] OFF_PB_SYS    = 12'h218; // System allocated
  localparam logic [11:0] OFF_ACS_HDR   = 12'h220; // ACS cap header
  localparam logic [11:0] OFF_ACS_CTL   = 12'h224; // ACS cap and control
  localparam logic [11:0] OFF_EGR_VEC   = 12'h228; // Egress control vector

  // Capability header fields
  localparam logic [15:0] PB_CAP_ID     = 16'h0004;
  localparam logic [15:0] ACS_CAP_ID    = 16'h000D;
  localparam logic [3:0]  CAP_VERSION   = 4'h1;
  localparam logic [11:0] NEXT_UP       = 12'h230;
  localparam logic [11:0] NEXT_DN       = 12'h220;
  localparam logic [11:0] NEXT_END      = 12'h000;

  // Data select index values
  localparam logic [7:0]  SEL_D0_MAX    = 8'h00;
  localparam logic [7:0]  SEL_D0_SUST   = 8'h01;
  localparam logic [7:0]  SEL_RST       = 8'h00;

  // Budget data word field defaults
  localparam logic [7:0]  BASE_PWR_RST  = 8'h04;
  localparam logic [1:0]  SCALE_RST     = 2'h0;
  localparam logic [2:0]  SUBST_RST     = 3'h0;
  localparam logic [1:0]  PMST_RST      = 2'h0;
  localparam logic [2:0]  TYPE_RST      = 3'h7;
  localparam logic [2:0]  RAIL_RST      = 3'h2;
  localparam logic        SYSALLOC_RST  = 1'h0;

  // ACS capability fields
  localparam logic [6:0]  ACS_FEAT_CAP  = 7'h7F;
  localparam logic [7:0]  EGR_VEC_SIZE  = 8'h08;
  localparam logic [6:0]  ACS_EN_RST    = 7'h00;
  localparam logic [7:0]  EGR_VEC_RST   = 8'h00;
  localparam int          ACS_EGR_BIT   = 5;     // Egress enable position

  // AXI response codes
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Write channel capture states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } pbac_wr_state_t;

endpackage

// File: rtl/pbac_regs.sv
// Power budget and ACS configuration registers for one switch port.
// Assumes an AXI4-Lite master, one write and one read in flight at most.
//
// Functional notes
// - Budget header ID reads 0004h, read-only
// - Every header reports version 1 in 19:16
// - Budget next pointer 230h up, 220h down
// - Eight-bit select resets zero; 0 max, 1 sustained
// - Other select values read all-zero data word
// - Base power bits 7:0 default 04h, loadable
// - Scale bits 9:8 reset to 00
// - Sub-state 12:10 and state 14:13 reset zero
// - Type field 17:15 resets to 111
// - Rail 20:18 resets 010; 31:21 reserved
// - System allocated flag bit 0, loadable, zero
// - ACS registers exist only on downstream ports
// - ACS header ID reads 000Dh, read-only
// - ACS next pointer reads zero
// - Capability bits 0..6 read one
// - Vector size field 15:8 reads 08h
// - Enables 16..22 read-write, reset zero
// - Egress vector bit blocks peer requests
`timescale 1ns/1ps
`default_nettype none

module pbac_regs
  import pbac_pkg::*;
(
  // Clock and reset
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  // Port role and default load
  input  wire  logic        is_downstream,
  input  wire  logic        load_valid,
  input  wire  logic [7:0]  load_base_power,
  input  wire  logic        load_sys_alloc,
  // AXI4-Lite write address
  input  wire  logic [11:0] s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [11:0] s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Peer routing control
  input  wire  logic [2:0]  p2p_target_port,
  output logic [6:0]        acs_enable,
  output logic              p2p_block
);

  ////////////////////////////////////////////////////////////////////////////
  // Stored state
  logic [7:0]     data_sel;      // Budget data index
  logic [7:0]     base_power;    // Loadable base power
  logic           sys_alloc;     // Loadable allocation flag
  logic [6:0]     acs_en;        // ACS feature enables
  logic [7:0]     egr_vec;       // Egress control vector
  logic           aw_held;       // Write address captured
  logic           w_held;        // Write data captured
  logic [11:0]    aw_addr;       // Captured write address
  logic [31:0]    w_data;        // Captured write data
  logic [3:0]     w_strb;        // Captured byte enables
  pbac_wr_state_t wr_state;      // Write response phase
  logic           wr_go;         // Both halves present

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: take address and data in either order
  assign s_axi_awready = (wr_state == WR_IDLE) && !aw_held;
  assign s_axi_wready  = (wr_state == WR_IDLE) && !w_held;
  assign wr_go         = (wr_state == WR_IDLE) && aw_held && w_held;

  // Capture address and data halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Decode for the committing write
  logic wr_map_ok;
  always_comb begin
    unique case (aw_addr)
      OFF_PB_HDR, OFF_PB_SEL, OFF_PB_DATA, OFF_PB_SYS: wr_map_ok = 1'b1;
      OFF_ACS_HDR, OFF_ACS_CTL, OFF_EGR_VEC: wr_map_ok = is_downstream;
      default: wr_map_ok = 1'b0;
    endcase
  end

  // Response phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state    <= WR_IDLE;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      unique case (wr_state)
        WR_IDLE: begin
          if (wr_go) begin
            wr_state    <= WR_RESP;
            s_axi_bresp <= wr_map_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= WR_IDLE;
          end
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end
  assign s_axi_bvalid = (wr_state == WR_RESP);

  ////////////////////////////////////////////////////////////////////////////
  // Writable fields; read-only and reserved bits are never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_sel <= SEL_RST;
      acs_en   <= ACS_EN_RST;
      egr_vec  <= EGR_VEC_RST;
    end else if (wr_go) begin
      // Only low byte of select is writable
      if (aw_addr == OFF_PB_SEL && w_strb[0]) begin
        data_sel <= w_data[7:0];
      end
      // ACS writes land only on downstream ports
      if (is_downstream && aw_addr == OFF_ACS_CTL) begin
        if (w_strb[2]) begin
          acs_en <= w_data[22:16];
        end
      end
      if (is_downstream && aw_addr == OFF_EGR_VEC && w_strb[0]) begin
        egr_vec <= w_data[7:0];
      end
    end
  end

  // Defaults loaded after reset by the configuration loader
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_power <= BASE_PWR_RST;
      sys_alloc  <= SYSALLOC_RST;
    end else if (load_valid) begin
      base_power <= load_base_power;
      sys_alloc  <= load_sys_alloc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read value mux, combinational so a fresh select shows at once
  logic [31:0] budget_word;
  logic [31:0] rd_value;
  logic        rd_map_ok;

  // Budget word; unsupported index returns zero
  always_comb begin
    if (data_sel == SEL_D0_MAX || data_sel == SEL_D0_SUST) begin
      budget_word = {11'h000, RAIL_RST, TYPE_RST, PMST_RST,
                     SUBST_RST, SCALE_RST, base_power};
    end else begin
      budget_word = 32'h0000_0000;
    end
  end

  // Address decode for reads
  always_comb begin
    rd_value  = 32'h0000_0000;
    rd_map_ok = 1'b1;
    unique case (s_axi_araddr)
      OFF_PB_HDR: begin
        rd_value = {(is_downstream ? NEXT_DN : NEXT_UP),
                    CAP_VERSION, PB_CAP_ID};
      end
      OFF_PB_SEL:  rd_value = {24'h000000, data_sel};
      OFF_PB_DATA: rd_value = budget_word;
      OFF_PB_SYS:  rd_value = {31'h0000_0000, sys_alloc};
      OFF_ACS_HDR: begin
        rd_map_ok = is_downstream;
        if (is_downstream) begin
          rd_value = {NEXT_END, CAP_VERSION, ACS_CAP_ID};
        end
      end
      OFF_ACS_CTL: begin
        rd_map_ok = is_downstream;
        if (is_downstream) begin
          rd_value = {9'h000, acs_en, EGR_VEC_SIZE,
                      1'b0, ACS_FEAT_CAP};
        end
      end
      OFF_EGR_VEC: begin
        rd_map_ok = is_downstream;
        if (is_downstream) begin
          rd_value = {24'h000000, egr_vec};
        end
      end
      default: rd_map_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one-cycle answer, held until taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_map_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing controls seen by the switch fabric
  assign acs_enable = is_downstream ? acs_en : ACS_EN_RST;
  // Blocking applies only while egress control is enabled
  assign p2p_block  = is_downstream && acs_en[ACS_EGR_BIT]
                      && egr_vec[p2p_target_port];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_sel_write(logic [7:0] v);
    wr_go && aw_addr == OFF_PB_SEL && w_strb[0] && w_data[7:0] == v;
  endsequence

  // Read address taken at one register offset
  sequence s_rd_take(logic [11:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence

  chk_sel_reset_zero: assert property (
    @(posedge aclk) $rose(aresetn) |-> data_sel == SEL_RST)
    else $error("select not zero after reset");

  chk_pb_header: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_PB_HDR
    |=> s_axi_rdata[15:0] == PB_CAP_ID && s_axi_rdata[19:16] == CAP_VERSION)
    else $error("budget header id or version wrong");

  chk_pb_next_ptr: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_PB_HDR
    |=> s_axi_rdata[31:20] == ($past(is_downstream) ? NEXT_DN : NEXT_UP))
    else $error("budget next pointer wrong");

  chk_bad_sel_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_rd_take(OFF_PB_DATA) ##0 data_sel > SEL_D0_SUST
    |=> s_axi_rdata == 32'h0000_0000)
    else $error("unsupported index gives nonzero data");

  chk_data_fields: assert property (
    @(posedge aclk) disable iff (!aresetn)
    data_sel <= SEL_D0_SUST |-> budget_word[17:15] == TYPE_RST
      && budget_word[20:18] == RAIL_RST && budget_word[31:21] == 11'h000)
    else $error("budget data fields wrong");

  chk_sel_then_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_sel_write(8'h02) |=> budget_word == 32'h0000_0000)
    else $error("select change not reflected");

  chk_acs_ctl_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_ACS_CTL
      && is_downstream
    |=> s_axi_rdata[15:0] == {EGR_VEC_SIZE, 1'b0, ACS_FEAT_CAP}
      && s_axi_rdata[31:23] == 9'h000)
    else $error("acs capability bits wrong");

  chk_acs_up_absent: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_ACS_HDR
      && !is_downstream |=> s_axi_rresp == RESP_SLVERR)
    else $error("acs visible on upstream port");

  chk_acs_en_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go && is_downstream && aw_addr == OFF_ACS_CTL && w_strb[2]
    |=> acs_en == w_data[22:16])
    else $error("acs enable write lost");

  chk_bresp_follows: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");

  // Sub-state, state and scale always read as their fixed defaults
  chk_fixed_fields: assert property (
    @(posedge aclk) disable iff (!aresetn)
    data_sel <= SEL_D0_SUST
    |-> budget_word[14:8] == {PMST_RST, SUBST_RST, SCALE_RST})
    else $error("state or scale field wrong");

  // Select reads back its stored byte with upper bits zero
  chk_sel_readback: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_rd_take(OFF_PB_SEL) |=> s_axi_rdata == {24'h000000, $past(data_sel)})
    else $error("select readback wrong");

  // Allocation flag in bit 0, everything above reserved
  chk_sys_alloc_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_rd_take(OFF_PB_SYS)
    |=> s_axi_rdata == {31'h0000_0000, $past(sys_alloc)})
    else $error("system allocated flag read wrong");

  // ACS header closes the capability list
  chk_acs_header: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_rd_take(OFF_ACS_HDR) ##0 is_downstream
    |=> s_axi_rdata == {NEXT_END, CAP_VERSION, ACS_CAP_ID})
    else $error("acs header wrong");

  // Upstream port never drives ACS controls to the fabric
  chk_acs_en_up: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !is_downstream |-> acs_enable == ACS_EN_RST && !p2p_block)
    else $error("acs controls active on upstream port");

  // Vector bits are inert while egress control is off
  chk_egress_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !acs_en[ACS_EGR_BIT] |-> !p2p_block)
    else $error("peer block without egress enable");

  // Loader replaces the base power default
  chk_base_load: assert property (
    @(posedge aclk) disable iff (!aresetn)
    load_valid |=> base_power == $past(load_base_power))
    else $error("base power load lost");

  // Software cannot move the read-only flag; only the loader can
  chk_ro_ignored: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_go && aw_addr == OFF_PB_SYS && !load_valid |=> $stable(sys_alloc))
    else $error("read-only flag changed by write");

endmodule

`default_nettype wire

// File: tb/pbac_regs_tb.sv
// Self-checking bench for the power budget and ACS register block.
// Assumes the bench alone drives every port; AXI4-Lite master tasks.
`timescale 1ns/1ps
`default_nettype none

module pbac_regs_tb
  import pbac_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////
  // Ports of the block under test
  logic        aclk, aresetn, is_downstream, load_valid, load_sys_alloc;
  logic [7:0]  load_base_power;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, p2p_block;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  p2p_target_port;
  logic [6:0]  acs_enable;
  int          mismatches, total_checks;
  // Budget word as it reads straight after reset
  localparam logic [31:0] DW = {11'h000, RAIL_RST, TYPE_RST, PMST_RST,
                                SUBST_RST, SCALE_RST, BASE_PWR_RST};
  // Egress vector pattern, mixed bits so each port lookup differs
  localparam logic [7:0]  EGR_PAT = 8'hA5;

  pbac_regs i_dut (
    .aclk(aclk), .aresetn(aresetn), .is_downstream(is_downstream),
    .load_valid(load_valid), .load_base_power(load_base_power),
    .load_sys_alloc(load_sys_alloc), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .p2p_target_port(p2p_target_port),
    .acs_enable(acs_enable), .p2p_block(p2p_block));

  // Free-running 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict and one-line checks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Bounded waits only, so a hung handshake ends the run
  task automatic timeout(input int n, input string msg);
    if (n >= 100) begin
      chk(1'b0, msg);
      report_and_stop();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master: both write halves offered together
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic [1:0] er);
    int   n;
    logic aw_on, w_on, b_on;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Local flags: the NBA values are not yet visible at this edge
    {aw_on, w_on, b_on} = 3'b111;
    n = 0;
    while ((aw_on || w_on || b_on) && n < 100) begin
      @(posedge aclk);
      n++;
      if (aw_on && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
      if (b_on && bvalid === 1'b1) begin
        chk(bresp === er, "write response");
        bready <= 1'b0;
        b_on = 1'b0;
      end
    end
    timeout(n, "write hung");
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    int   n;
    logic ar_on, r_on;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    {ar_on, r_on} = 2'b11;
    n = 0;
    while ((ar_on || r_on) && n < 100) begin
      @(posedge aclk);
      n++;
      if (ar_on && arready === 1'b1) begin
        arvalid <= 1'b0;
        ar_on = 1'b0;
      end
      if (r_on && rvalid === 1'b1) begin
        chk(rdata === ed && rresp === er, "read data or response");
        rready <= 1'b0;
        r_on = 1'b0;
      end
    end
    timeout(n, "read hung");
  endtask

  // Synchronous reset held 20 cycles; port role set while in reset
  task automatic do_reset(input logic dn);
    @(posedge aclk);
    aresetn       <= 1'b0;
    is_downstream <= dn;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0]  sels [5];
    logic [31:0] v;
    sels = '{8'h00, 8'h01, 8'h02, 8'h80, 8'hFF};
    {aresetn, is_downstream, load_valid, load_sys_alloc} = 4'h4;
    load_base_power = 8'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    p2p_target_port = 3'h0;
    mismatches = 0;
    total_checks = 0;
    do_reset(1'b1);
    // Reset values on a downstream port; RO writes leave them alone
    axi_read(OFF_PB_HDR, {NEXT_DN, CAP_VERSION, PB_CAP_ID}, RESP_OKAY);
    axi_read(OFF_PB_SEL, 32'h00000000, RESP_OKAY);
    axi_read(OFF_PB_DATA, DW, RESP_OKAY);
    axi_read(OFF_PB_SYS, 32'h00000000, RESP_OKAY);
    axi_read(OFF_ACS_HDR, {NEXT_END, CAP_VERSION, ACS_CAP_ID}, RESP_OKAY);
    axi_read(OFF_ACS_CTL, 32'h0000087F, RESP_OKAY);
    chk(acs_enable === 7'h00, "enables after reset");
    axi_write(OFF_PB_HDR, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    axi_write(OFF_PB_DATA, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    axi_write(OFF_PB_SYS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    axi_read(OFF_PB_HDR, {NEXT_DN, CAP_VERSION, PB_CAP_ID}, RESP_OKAY);
    axi_read(OFF_PB_DATA, DW, RESP_OKAY);
    axi_read(OFF_PB_SYS, 32'h00000000, RESP_OKAY);
    $display("test reset_values done");
    // Select index: reserved upper bits drop, unknown indexes read zero
    axi_write(OFF_PB_SEL, 32'hFFFFFF01, 4'hF, RESP_OKAY);
    axi_read(OFF_PB_SEL, 32'h00000001, RESP_OKAY);
    foreach (sels[i]) begin
      axi_write(OFF_PB_SEL, {24'h000000, sels[i]}, 4'hF, RESP_OKAY);
      v = (sels[i] < 8'h02) ? DW : 32'h00000000;
      axi_read(OFF_PB_DATA, v, RESP_OKAY);
    end
    axi_write(OFF_PB_SEL, 32'h00000000, 4'hF, RESP_OKAY);
    $display("test data_select done");
    // Default override, as from the serial memory load
    @(posedge aclk);
    load_valid      <= 1'b1;
    load_base_power <= 8'h1E;
    load_sys_alloc  <= 1'b1;
    @(posedge aclk);
    load_valid <= 1'b0;
    axi_read(OFF_PB_DATA, {DW[31:8], 8'h1E}, RESP_OKAY);
    axi_read(OFF_PB_SYS, 32'h00000001, RESP_OKAY);
    $display("test default_load done");
    // Each enable alone, then a write without lane 2 must not touch them
    for (int i = 0; i < 7; i++) begin
      v = 32'h00000001 << (16 + i);
      axi_write(OFF_ACS_CTL, v | 32'hFF80FFFF, 4'hF, RESP_OKAY);
      chk(acs_enable === (7'h01 << i), "enable output");
      axi_read(OFF_ACS_CTL, v | 32'h0000087F, RESP_OKAY);
    end
    axi_write(OFF_ACS_CTL, 32'h00000000, 4'hB, RESP_OKAY);
    chk(acs_enable === 7'h40, "strobe gating");
    $display("test acs_enables done");
    // Egress blocking follows the vector only while egress is enabled
    axi_write(OFF_EGR_VEC, {24'h000000, EGR_PAT}, 4'hF, RESP_OKAY);
    axi_read(OFF_EGR_VEC, {24'h000000, EGR_PAT}, RESP_OKAY);
    axi_write(OFF_ACS_CTL, 32'h00200000, 4'hF, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      p2p_target_port <= i[2:0];
      @(negedge aclk);
      chk(p2p_block === EGR_PAT[i], "egress block");
    end
    axi_write(OFF_ACS_CTL, 32'h00000000, 4'hF, RESP_OKAY);
    @(negedge aclk);
    chk(p2p_block === 1'b0, "block with egress off");
    $display("test egress done");
    // Unmapped offset refused
    axi_read(12'h300, 32'h00000000, RESP_SLVERR);
    axi_write(12'h300, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
    $display("test unmapped done");
    // Upstream port: other next pointer, no ACS registers
    do_reset(1'b0);
    axi_read(OFF_PB_HDR, {NEXT_UP, CAP_VERSION, PB_CAP_ID}, RESP_OKAY);
    axi_read(OFF_PB_DATA, DW, RESP_OKAY);
    axi_read(OFF_ACS_HDR, 32'h00000000, RESP_SLVERR);
    axi_write(OFF_ACS_CTL, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
    axi_read(OFF_ACS_CTL, 32'h00000000, RESP_SLVERR);
    chk(acs_enable === 7'h00 && p2p_block === 1'b0, "upstream acs");
    $display("test upstream done");
    report_and_stop();
  end
endmodule

`default_nettype wire
